// *** hw/aex_cfg.svh ***
// Constants for the accumulator extract and shift unit.
// Assumes it is included by bare name from the package and design modules.
`ifndef AEX_CFG_SVH
`define AEX_CFG_SVH

`define AEX_ACC_W      64
`define AEX_WORD_W     32
`define AEX_HALF_W     16
`define AEX_SH_W       5
`define AEX_ASH_W      6
`define AEX_POS_W      6
`define AEX_SEL_W      2
`define AEX_NUM_ACC    4
`define AEX_POS_RESET  6'h00
`define AEX_POS_ADV    6'h20
`define AEX_FIELD_BIAS 7'h20
`define AEX_Q31_MAX    32'h7FFFFFFF
`define AEX_Q15_MAX    32'h00007FFF
`define AEX_Q15_MIN    32'hFFFF8000
`define AEX_WORD_ZERO  32'h00000000

`endif

// *** hw/aex_pkg.sv ***
// Types shared by the accumulator extract and shift unit.
// Assumes the core decoder maps each instruction onto one operation code.
`include "aex_cfg.svh"

package aex_pkg;

    typedef enum logic [4:0] {
        AEX_OP_NOP            = 5'h00,
        AEX_OP_EXT_W_IMM      = 5'h01,
        AEX_OP_EXT_W_RND_IMM  = 5'h02,
        AEX_OP_EXT_W_RS_IMM   = 5'h03,
        AEX_OP_EXT_H_SAT_IMM  = 5'h04,
        AEX_OP_EXT_H_SAT_REG  = 5'h05,
        AEX_OP_EXT_W_REG      = 5'h06,
        AEX_OP_EXT_W_RND_REG  = 5'h07,
        AEX_OP_EXT_W_RS_REG   = 5'h08,
        AEX_OP_FIELD_IMM      = 5'h09,
        AEX_OP_FIELD_REG      = 5'h0A,
        AEX_OP_FIELD_DEC_IMM  = 5'h0B,
        AEX_OP_FIELD_DEC_REG  = 5'h0C,
        AEX_OP_ACC_SHIFT_IMM  = 5'h0D,
        AEX_OP_ACC_SHIFT_REG  = 5'h0E,
        AEX_OP_ACC_MOVE_ADV   = 5'h0F,
        AEX_OP_READ_HIGH      = 5'h10,
        AEX_OP_READ_LOW       = 5'h11,
        AEX_OP_WRITE_HIGH     = 5'h12,
        AEX_OP_WRITE_LOW      = 5'h13
    } aex_op_t;

endpackage

// *** hw/aex_word_extract.sv ***
// Word and halfword extraction from a 64-bit accumulator value.
// Assumes a purely combinational use inside the unit's top module.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_word_extract (
    input  logic [`AEX_ACC_W-1:0]  acc,
    input  logic [`AEX_SH_W-1:0]   shamt,
    input  logic                   round_en,
    input  logic                   sat_en,
    input  logic                   half_mode,
    output logic [`AEX_WORD_W-1:0] result
);
    // An extra guard bit below the accumulator keeps the first discarded bit for rounding.
    logic [`AEX_ACC_W:0]    widened;
    logic [`AEX_ACC_W:0]    rounded;
    logic [`AEX_ACC_W-1:0]  trunc;
    logic [`AEX_ACC_W-1:0]  rnd;
    logic                   word_ovf;
    logic                   half_fits;
    logic [`AEX_WORD_W-1:0] word_val;
    logic [`AEX_WORD_W-1:0] half_val;

    assign widened  = {acc, 1'b0} >> shamt;
    assign rounded  = widened + {{`AEX_ACC_W{1'b0}}, round_en};
    assign trunc    = widened[`AEX_ACC_W:1];
    assign rnd      = rounded[`AEX_ACC_W:1];
    // Overflow here means rounding carried a positive value into the sign bit.
    assign word_ovf = sat_en & ~trunc[`AEX_WORD_W-1] & rnd[`AEX_WORD_W-1];
    assign word_val = word_ovf ? `AEX_Q31_MAX :
                      (round_en ? rnd[`AEX_WORD_W-1:0] : trunc[`AEX_WORD_W-1:0]);
    assign half_fits = (&trunc[`AEX_ACC_W-1:`AEX_HALF_W-1]) |
                       ~(|trunc[`AEX_ACC_W-1:`AEX_HALF_W-1]);
    assign half_val = half_fits ?
                      {{`AEX_HALF_W{trunc[`AEX_HALF_W-1]}}, trunc[`AEX_HALF_W-1:0]} :
                      (trunc[`AEX_ACC_W-1] ? `AEX_Q15_MIN : `AEX_Q15_MAX);
    assign result   = half_mode ? half_val : word_val;

endmodule

// *** hw/aex_field_extract.sv ***
// Variable bit-field extraction from a 64-bit accumulator value.
// Assumes a purely combinational use inside the unit's top module.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_field_extract (
    input  logic [`AEX_ACC_W-1:0]  acc,
    input  logic [`AEX_POS_W-1:0]  pos,
    input  logic [`AEX_SH_W-1:0]   size,
    output logic [`AEX_WORD_W-1:0] result,
    output logic                   short_field
);
    // Zeros padded below bit 0 keep the shift non-negative when the field would run off the end.
    logic [`AEX_ACC_W+`AEX_WORD_W-1:0] padded;
    logic [`AEX_POS_W:0]               offset;

    assign offset      = {1'b0, pos} + `AEX_FIELD_BIAS - {2'b00, size};
    assign padded      = {acc, `AEX_WORD_ZERO} >> offset;
    assign short_field = pos < {1'b0, size};

    always_comb begin
        for (int i = 0; i < `AEX_WORD_W; i++) begin
            result[i] = (i <= int'(size)) ? padded[i] : padded[size];
        end
    end

endmodule

// *** hw/aex_unit.sv ***
// Top of the accumulator extract and shift unit: four accumulators, the position
// field of the DSP control register, and the operation sequencing.
// Assumes the core pipeline presents one decoded operation per cycle with operands,
// and that the control-register write path drives pos_write when software loads it.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_unit #(
    parameter int NUM_ACC = `AEX_NUM_ACC
) (
    input  logic                   clk,
    input  logic                   rstn,
    input  logic                   op_valid,
    input  aex_pkg::aex_op_t       op_code,
    input  logic [`AEX_SEL_W-1:0]  accumulator_select,
    input  logic [`AEX_WORD_W-1:0] source_gpr,
    input  logic [`AEX_SH_W-1:0]   imm_shift,
    input  logic [`AEX_ASH_W-1:0]  imm_acc_shift,
    input  logic [`AEX_SH_W-1:0]   imm_size,
    input  logic                   pos_write,
    input  logic [`AEX_POS_W-1:0]  pos_wdata,
    output logic [`AEX_WORD_W-1:0] target_gpr,
    output logic                   target_gpr_we,
    output logic                   field_short,
    output logic [`AEX_POS_W-1:0]  pos
);
    import aex_pkg::*;

    logic [`AEX_WORD_W-1:0] acc_high_word [NUM_ACC];
    logic [`AEX_WORD_W-1:0] acc_low_word  [NUM_ACC];

    logic [`AEX_ACC_W-1:0]  acc_cur;
    logic                   is_word_imm;
    logic                   is_word_reg;
    logic                   is_half;
    logic                   is_word;
    logic                   is_round;
    logic                   is_sat;
    logic                   is_field;
    logic                   is_field_reg;
    logic                   is_field_dec;
    logic                   is_shift;
    logic                   is_shift_reg;
    logic                   uses_reg_shift;
    logic                   writes_gpr;
    logic [`AEX_SH_W-1:0]   ext_shamt;
    logic [`AEX_SH_W-1:0]   field_size;
    logic [`AEX_ASH_W-1:0]  acc_shamt;
    logic [`AEX_WORD_W-1:0] word_result;
    logic [`AEX_WORD_W-1:0] field_result;
    logic                   field_short_now;
    logic [`AEX_ACC_W-1:0]  shifted_acc;
    logic [`AEX_WORD_W-1:0] next_target_gpr;
    logic [`AEX_POS_W-1:0]  next_pos;

    // Signed shift of the whole accumulator; right shifts are logical.
    function automatic logic [`AEX_ACC_W-1:0] acc_shift(
        input logic [`AEX_ACC_W-1:0] value,
        input logic [`AEX_ASH_W-1:0] amount
    );
        logic [`AEX_ASH_W:0] magnitude;
        magnitude = {1'b0, amount};
        if (amount[`AEX_ASH_W-1]) begin
            magnitude = {1'b0, ~amount} + {{`AEX_ASH_W{1'b0}}, 1'b1};
            acc_shift = value >> magnitude;
        end else begin
            acc_shift = value << magnitude;
        end
    endfunction

    assign acc_cur = {acc_high_word[accumulator_select],
                      acc_low_word[accumulator_select]};

    assign is_word_imm  = (op_code == AEX_OP_EXT_W_IMM) |
                          (op_code == AEX_OP_EXT_W_RND_IMM) |
                          (op_code == AEX_OP_EXT_W_RS_IMM);
    assign is_word_reg  = (op_code == AEX_OP_EXT_W_REG) |
                          (op_code == AEX_OP_EXT_W_RND_REG) |
                          (op_code == AEX_OP_EXT_W_RS_REG);
    assign is_word      = is_word_imm | is_word_reg;
    assign is_half      = (op_code == AEX_OP_EXT_H_SAT_IMM) |
                          (op_code == AEX_OP_EXT_H_SAT_REG);
    assign is_round     = (op_code == AEX_OP_EXT_W_RND_IMM) |
                          (op_code == AEX_OP_EXT_W_RS_IMM) |
                          (op_code == AEX_OP_EXT_W_RND_REG) |
                          (op_code == AEX_OP_EXT_W_RS_REG);
    assign is_sat       = (op_code == AEX_OP_EXT_W_RS_IMM) |
                          (op_code == AEX_OP_EXT_W_RS_REG);
    assign is_field_reg = (op_code == AEX_OP_FIELD_REG) |
                          (op_code == AEX_OP_FIELD_DEC_REG);
    assign is_field_dec = (op_code == AEX_OP_FIELD_DEC_IMM) |
                          (op_code == AEX_OP_FIELD_DEC_REG);
    assign is_field     = is_field_reg | is_field_dec | (op_code == AEX_OP_FIELD_IMM);
    assign is_shift_reg = (op_code == AEX_OP_ACC_SHIFT_REG);
    assign is_shift     = is_shift_reg | (op_code == AEX_OP_ACC_SHIFT_IMM);
    assign uses_reg_shift = is_word_reg | (op_code == AEX_OP_EXT_H_SAT_REG);
    assign writes_gpr   = is_word | is_half | is_field |
                          (op_code == AEX_OP_READ_HIGH) | (op_code == AEX_OP_READ_LOW);

    // The immediate port is only five bits wide, so any larger shift cannot be asked for.
    assign ext_shamt  = uses_reg_shift ? source_gpr[`AEX_SH_W-1:0] : imm_shift;
    assign field_size = is_field_reg ? source_gpr[`AEX_SH_W-1:0] : imm_size;
    assign acc_shamt  = is_shift_reg ? source_gpr[`AEX_ASH_W-1:0] : imm_acc_shift;
    // Passing the accumulator through unchanged keeps the shifter quiet on other operations.
    assign shifted_acc = is_shift ? acc_shift(acc_cur, acc_shamt) : acc_cur;

    aex_word_extract u_word (
        .acc       (acc_cur),
        .shamt     (ext_shamt),
        .round_en  (is_round),
        .sat_en    (is_sat),
        .half_mode (is_half),
        .result    (word_result)
    );

    aex_field_extract u_field (
        .acc         (acc_cur),
        .pos         (pos),
        .size        (field_size),
        .result      (field_result),
        .short_field (field_short_now)
    );

    always_comb begin
        next_target_gpr = `AEX_WORD_ZERO;
        if (is_word | is_half) begin
            next_target_gpr = word_result;
        end else if (is_field) begin
            next_target_gpr = field_result;
        end else if (op_code == AEX_OP_READ_HIGH) begin
            next_target_gpr = acc_high_word[accumulator_select];
        end else if (op_code == AEX_OP_READ_LOW) begin
            next_target_gpr = acc_low_word[accumulator_select];
        end
    end

    // An operation that moves the position wins over a software load in the same cycle,
    // because the load is an older instruction already retired in program order.
    always_comb begin
        next_pos = pos;
        if (pos_write) begin
            next_pos = pos_wdata;
        end
        if (op_valid & is_field_dec) begin
            next_pos = pos - ({1'b0, field_size} + {{`AEX_SH_W{1'b0}}, 1'b1});
        end else if (op_valid & (op_code == AEX_OP_ACC_MOVE_ADV)) begin
            next_pos = pos + `AEX_POS_ADV;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pos <= `AEX_POS_RESET;
        end else begin
            pos <= next_pos;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            target_gpr    <= `AEX_WORD_ZERO;
            target_gpr_we <= 1'b0;
            field_short   <= 1'b0;
        end else begin
            target_gpr_we <= op_valid & writes_gpr;
            field_short   <= op_valid & is_field & field_short_now;
            if (op_valid & writes_gpr) begin
                target_gpr <= next_target_gpr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_ACC; i++) begin
                acc_high_word[i] <= `AEX_WORD_ZERO;
                acc_low_word[i]  <= `AEX_WORD_ZERO;
            end
        end else if (op_valid) begin
            case (op_code)
                AEX_OP_ACC_SHIFT_IMM, AEX_OP_ACC_SHIFT_REG: begin
                    acc_high_word[accumulator_select] <= shifted_acc[`AEX_ACC_W-1:`AEX_WORD_W];
                    acc_low_word[accumulator_select]  <= shifted_acc[`AEX_WORD_W-1:0];
                end
                AEX_OP_ACC_MOVE_ADV: begin
                    acc_high_word[accumulator_select] <= acc_low_word[accumulator_select];
                    acc_low_word[accumulator_select]  <= source_gpr;
                end
                AEX_OP_WRITE_HIGH: begin
                    acc_high_word[accumulator_select] <= source_gpr;
                end
                AEX_OP_WRITE_LOW: begin
                    acc_low_word[accumulator_select] <= source_gpr;
                end
                default: begin
                end
            endcase
        end
    end

endmodule

// *** sim/aex_unit_checker.sv ***
// Port-level assertions for the accumulator extract and shift unit.
// Assumes one clock domain and the synchronous active-low reset of the unit.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_unit_checker #(
    parameter int NUM_ACC = 4
) (
    input logic                   clk,
    input logic                   rstn,
    input logic                   op_valid,
    input aex_pkg::aex_op_t       op_code,
    input logic [`AEX_SEL_W-1:0]  accumulator_select,
    input logic [`AEX_WORD_W-1:0] source_gpr,
    input logic [`AEX_SH_W-1:0]   imm_shift,
    input logic [`AEX_ASH_W-1:0]  imm_acc_shift,
    input logic [`AEX_SH_W-1:0]   imm_size,
    input logic                   pos_write,
    input logic [`AEX_POS_W-1:0]  pos_wdata,
    input logic [`AEX_WORD_W-1:0] target_gpr,
    input logic                   target_gpr_we,
    input logic                   field_short,
    input logic [`AEX_POS_W-1:0]  pos
);
    import aex_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire gpr_op = op_valid && (op_code inside {[AEX_OP_EXT_W_IMM:AEX_OP_FIELD_DEC_REG],
        AEX_OP_READ_HIGH, AEX_OP_READ_LOW});
    wire acc_op = op_valid && (op_code inside {[AEX_OP_ACC_SHIFT_IMM:AEX_OP_ACC_MOVE_ADV],
        AEX_OP_WRITE_HIGH, AEX_OP_WRITE_LOW});

    a_we_needs_op: assert property (target_gpr_we |-> $past(gpr_op))
        else $error("result pulse without a register-writing operation");
    a_op_gives_we: assert property (gpr_op |=> target_gpr_we)
        else $error("register-writing operation gave no result pulse");
    a_acc_op_quiet: assert property (acc_op |=> !target_gpr_we)
        else $error("accumulator operation pulsed the result");
    a_adv_pos_step: assert property (op_valid && op_code == AEX_OP_ACC_MOVE_ADV
        |=> pos == 6'($past(pos) + 6'h20)) else $error("advance did not add 32 to position");
    a_dec_pos_imm: assert property (op_valid && op_code == AEX_OP_FIELD_DEC_IMM
        |=> pos == 6'($past(pos) - $past(imm_size) - 6'h01)) else $error("bad decrement");
    a_dec_pos_reg: assert property (op_valid && op_code == AEX_OP_FIELD_DEC_REG
        |=> pos == 6'($past(pos) - $past(source_gpr[4:0]) - 6'h01)) else $error("bad decrement");
    a_low_readback: assert property (op_valid && op_code == AEX_OP_WRITE_LOW ##1
        op_valid && op_code == AEX_OP_READ_LOW && $stable(accumulator_select)
        |=> target_gpr == $past(source_gpr, 2)) else $error("low word read back wrong");
    a_half_clamp: assert property (target_gpr_we && $past(op_code) inside
        {AEX_OP_EXT_H_SAT_IMM, AEX_OP_EXT_H_SAT_REG}
        |-> target_gpr[31:15] inside {17'h00000, 17'h1FFFF}) else $error("halfword not in range");
    a_short_cause: assert property (op_valid && op_code == AEX_OP_FIELD_IMM
        |=> field_short == ($past(pos) < $past(imm_size))) else $error("short flag wrong");
    a_short_with_we: assert property (field_short |-> target_gpr_we)
        else $error("short flag without result pulse");
endmodule

bind aex_unit aex_unit_checker #(.NUM_ACC(NUM_ACC)) u_chk (
    .clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .accumulator_select(accumulator_select), .source_gpr(source_gpr), .imm_shift(imm_shift),
    .imm_acc_shift(imm_acc_shift), .imm_size(imm_size), .pos_write(pos_write),
    .pos_wdata(pos_wdata), .target_gpr(target_gpr), .target_gpr_we(target_gpr_we),
    .field_short(field_short), .pos(pos)
);

// *** sim/aex_core_model.sv ***
// Model of the core pipeline that issues one decoded operation per cycle.
// Assumes the bench calls issue and idle from one process, one call per clock.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_core_model (
    input  logic                   clk,
    output logic                   op_valid,
    output aex_pkg::aex_op_t       op_code,
    output logic [`AEX_SEL_W-1:0]  accumulator_select,
    output logic [`AEX_WORD_W-1:0] source_gpr,
    output logic [`AEX_SH_W-1:0]   imm_shift,
    output logic [`AEX_ASH_W-1:0]  imm_acc_shift,
    output logic [`AEX_SH_W-1:0]   imm_size,
    output logic                   pos_write,
    output logic [`AEX_POS_W-1:0]  pos_wdata
);
    import aex_pkg::*;
    initial begin
        {op_valid, accumulator_select, source_gpr, imm_shift} = '0;
        {imm_acc_shift, imm_size, pos_write, pos_wdata} = '0;
        op_code = AEX_OP_NOP;
    end
    task automatic issue(input aex_op_t op, input logic [1:0] s, input logic [31:0] src,
                         input logic [4:0] sh, input logic [5:0] ash, input logic [4:0] sz,
                         input logic pw, input logic [5:0] pwd);
        @(posedge clk);
        #1;
        op_code = op;
        {op_valid, accumulator_select, source_gpr} = {1'b1, s, src};
        {imm_shift, imm_acc_shift, imm_size, pos_write, pos_wdata} = {sh, ash, sz, pw, pwd};
    endtask
    // The source register, shift and size operands do not hold their last value when idle, so a stale read shows up.
    task automatic idle();
        @(posedge clk);
        #1;
        {op_valid, pos_write} = 2'h0;
        {source_gpr, imm_size, imm_shift} = ~{source_gpr, imm_size, imm_shift};
    endtask
endmodule

// *** sim/aex_unit_tb_top.sv ***
// Self-checking bench for the accumulator extract and shift unit.
// Assumes the core model drives the operation port and a bound checker watches the ports.
`timescale 1ns/1ns
`include "aex_cfg.svh"

module aex_unit_tb_top;
    import aex_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    wire logic op_valid, pos_write, target_gpr_we, field_short;
    wire aex_op_t op_code;
    wire logic [1:0] accumulator_select;
    wire logic [31:0] source_gpr, target_gpr;
    wire logic [4:0] imm_shift, imm_size;
    wire logic [5:0] imm_acc_shift, pos_wdata, pos;
    logic [63:0] acc [4] = '{default: 64'h0};
    logic [5:0] p = 6'h00;
    logic [32:0] exp_q [$];
    int n_fail = 0;
    int num_checks = 0;
    int seed = 76177;
    always #10 clk = ~clk;
    aex_core_model core (.clk(clk), .op_valid(op_valid), .op_code(op_code),
        .accumulator_select(accumulator_select), .source_gpr(source_gpr), .imm_shift(imm_shift),
        .imm_acc_shift(imm_acc_shift), .imm_size(imm_size), .pos_write(pos_write),
        .pos_wdata(pos_wdata));
    aex_unit dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
        .accumulator_select(accumulator_select), .source_gpr(source_gpr), .imm_shift(imm_shift),
        .imm_acc_shift(imm_acc_shift), .imm_size(imm_size), .pos_write(pos_write),
        .pos_wdata(pos_wdata), .target_gpr(target_gpr), .target_gpr_we(target_gpr_we),
        .field_short(field_short), .pos(pos));
    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Result pulses are matched in order against the notes left by do_op.
    // Registered outputs are looked at mid-cycle, where they have settled.
    always @(negedge clk) begin
        if (rstn && target_gpr_we === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected result", 33'h1FFFFFFFF, 33'h0);
            else check("result", exp_q.pop_front(), {field_short, target_gpr});
        end
    end
    task automatic do_op(input aex_op_t op, input logic [1:0] s, input logic [31:0] src,
                         input logic [4:0] sh, input logic [5:0] ash, input logic [4:0] sz,
                         input logic pw = 1'b0, input logic [5:0] pwd = 6'h00);
        logic [63:0] a;
        logic [65:0] r;
        logic [95:0] t;
        logic [31:0] w;
        logic [4:0] n;
        logic [5:0] m;
        logic [5:0] p0;
        logic q;
        p0 = p;
        {a, w, q} = {acc[s], 33'h0};
        n = (op inside {[AEX_OP_FIELD_IMM:AEX_OP_FIELD_DEC_REG]}) ? sz : sh;
        if (op inside {[AEX_OP_EXT_H_SAT_REG:AEX_OP_EXT_W_RS_REG], AEX_OP_FIELD_REG,
            AEX_OP_FIELD_DEC_REG}) n = src[4:0];
        if (op inside {[AEX_OP_EXT_W_IMM:AEX_OP_EXT_W_RS_IMM], [6:8]}) begin
            r = (({1'b0, a, 1'b0} >> n) + 66'h1) >> 1;
            w = 32'(a >> n);
            if (op inside {AEX_OP_EXT_W_RS_IMM, AEX_OP_EXT_W_RS_REG} && !w[31] && r[31])
                w = 32'h7FFFFFFF;
            else if (!(op inside {AEX_OP_EXT_W_IMM, AEX_OP_EXT_W_REG})) w = r[31:0];
        end else if (op inside {AEX_OP_EXT_H_SAT_IMM, AEX_OP_EXT_H_SAT_REG}) begin
            r = 66'(a >> n);
            w = (r[63:15] == '0 || r[63:15] == '1) ? r[31:0] :
                (r[63] ? 32'hFFFF8000 : 32'h00007FFF);
        end else if (op inside {[AEX_OP_FIELD_IMM:AEX_OP_FIELD_DEC_REG]}) begin
            t = {a, 32'h0} >> (7'(p) + 7'h20 - 7'(n));
            m = 6'd31 - 6'(n);
            w = 32'($signed(t[31:0] << m) >>> m);
            q = p < 6'(n);
            if (op inside {AEX_OP_FIELD_DEC_IMM, AEX_OP_FIELD_DEC_REG}) p = p - 6'(n) - 6'h01;
        end else if (op inside {AEX_OP_ACC_SHIFT_IMM, AEX_OP_ACC_SHIFT_REG}) begin
            m = (op == AEX_OP_ACC_SHIFT_REG) ? src[5:0] : ash;
            a = m[5] ? a >> 6'(-m) : a << m;
        end else if (op == AEX_OP_ACC_MOVE_ADV) begin
            a = {a[31:0], src};
            p = p + 6'h20;
        end
        if (op == AEX_OP_READ_HIGH) w = a[63:32];
        if (op == AEX_OP_READ_LOW) w = a[31:0];
        if (op == AEX_OP_WRITE_HIGH) a[63:32] = src;
        if (op == AEX_OP_WRITE_LOW) a[31:0] = src;
        if (pw && !(op inside {AEX_OP_FIELD_DEC_IMM, AEX_OP_FIELD_DEC_REG, AEX_OP_ACC_MOVE_ADV}))
            p = pwd;
        acc[s] = a;
        if (op inside {[AEX_OP_EXT_W_IMM:AEX_OP_FIELD_DEC_REG], AEX_OP_READ_HIGH,
            AEX_OP_READ_LOW}) exp_q.push_back({q, w});
        core.issue(op, s, src, sh, ash, sz, pw, pwd);
        // The previous operation has now been taken, so the position must match its note.
        check("pos", {27'h0, p0}, {27'h0, pos});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        for (int s = 0; s < 4; s++) begin
            do_op(AEX_OP_READ_HIGH, 2'(s), 32'h0, 5'h0, 6'h0, 5'h0);
            do_op(AEX_OP_WRITE_HIGH, 2'(s), $random(seed), 5'h0, 6'h0, 5'h0);
            do_op(AEX_OP_WRITE_LOW, 2'(s), $random(seed), 5'h0, 6'h0, 5'h0);
            do_op(AEX_OP_READ_LOW, 2'(s), 32'h0, 5'h0, 6'h0, 5'h0);
        end
        do_op(AEX_OP_WRITE_HIGH, 2'h1, 32'h0, 5'h0, 6'h0, 5'h0);
        do_op(AEX_OP_WRITE_LOW, 2'h1, 32'hFFFFFFFF, 5'h0, 6'h0, 5'h0);
        for (int k = 1; k < 9; k++) do_op(aex_op_t'(k), 2'h1, 32'hFFFFFFE1, 5'h1, 6'h0, 5'h0);
        do_op(AEX_OP_EXT_W_RS_IMM, 2'h1, 32'h0, 5'h1F, 6'h0, 5'h0);
        do_op(AEX_OP_FIELD_DEC_IMM, 2'h0, 32'h0, 5'h0, 6'h0, 5'h3, 1'b1, 6'h3F);
        do_op(AEX_OP_NOP, 2'h0, 32'h0, 5'h0, 6'h0, 5'h0, 1'b1, 6'h02);
        do_op(AEX_OP_FIELD_IMM, 2'h0, 32'h0, 5'h0, 6'h0, 5'h1F);
        do_op(AEX_OP_ACC_SHIFT_IMM, 2'h2, 32'h0, 5'h0, 6'h20, 5'h0);
        do_op(AEX_OP_ACC_SHIFT_IMM, 2'h3, 32'h0, 5'h0, 6'h1F, 5'h0);
        do_op(AEX_OP_WRITE_HIGH, 2'h3, 32'h80000000, 5'h0, 6'h0, 5'h0);
        do_op(AEX_OP_EXT_H_SAT_IMM, 2'h3, 32'h0, 5'h0, 6'h0, 5'h0);
        for (int i = 0; i < 800; i++) begin
            do_op(aex_op_t'(5'($unsigned($random(seed)) % 20)), 2'($random(seed)),
                $random(seed), 5'($random(seed)), 6'($random(seed)), 5'($random(seed)),
                ($random(seed) & 7) == 0, 6'($random(seed)));
            if (($random(seed) & 15) == 0) core.idle();
        end
        core.idle();
        repeat (3) @(posedge clk);
        check("pending results", 33'h0, 33'(exp_q.size()));
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("[ERR] run limit expected end seen still running");
        conclude();
    end
endmodule
